/* rtl/iee_pkg.sv */
// Constants, types and register map of the two-wire serial memory slave.
// Contract
// (R01) Slave acks each written byte in slot nine unless write inhibit is high.
// (R02) Master acks each byte it reads except the last, which it nacks.
// (R03) Master stops after ack (write) or nack (read).
// (R04) Only a master Start opens a transfer.
// (R05) Select byte carries direction in bit 0, acked.
// (R06) Upper select nibble must match built-in type.
// (R07) Straps give expected select bits three to one.
// (R08) Unconnected straps read as zero.
// (R09) Select byte arrives most significant bit first.
// (R10) Write inhibit high blocks every array write; APB writes through REG_MDATA ignore it.
// (R11) Unconnected write inhibit reads low.
// (R12) Inhibited: select, address acked; data not acked.
// (R13) Supply reset active: ignore all bus traffic.
// (R14) Supply reset active: logic held in standby.
// (R15) Supply reset reasserted: reset and stop answering.
// (R16) Stop enters standby unless write cycle runs.
// (R17) Data line only pulled low or released.
// (R18) Array holds 16384 bytes, byte addressed.
// (R19) Address sent as high byte then low byte.
// (R20) Serial clock paces every data bit.
// (R21) Direction bit one reads, zero writes.
// (R22) Data sampled on rising serial clock edge.
// (R23) Strap mismatch: no ack, back to standby.
// (R24) Stop after write ack starts busy write cycle.
// (R25) Lines oversampled; Start, Stop seen clock-high.
// (R26) Write cycle is a busy interval, bus blocked.
package iee_pkg;
    localparam int         CLK_NS          = 8;
    localparam int         WRITE_CYCLE_NS  = 5000000;
    localparam int         WRITE_CYCLE_CYC = (WRITE_CYCLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int         ADDR_W          = 14;
    localparam int         MEM_DEPTH       = 16384;
    localparam int         PAGE_W          = 6;
    localparam int         PAGE_DEPTH      = 64;
    localparam logic [3:0] LAST_BIT        = 4'h8;
    // Pin positions inside the synchroniser vector.
    localparam int         LN_SCL          = 0;
    localparam int         LN_SDA          = 1;
    localparam int         LN_POR          = 2;
    localparam int         LN_WI           = 3;
    localparam int         LN_STRAP        = 4;
    localparam int         LN_W            = 7;
    localparam logic [6:0] LN_RESET        = 7'h07;
    // Select byte fields.
    localparam int         SEL_TYPE_LSB    = 4;
    localparam int         SEL_STRAP_LSB   = 1;
    localparam int         SEL_DIR         = 0;
    localparam logic       DIR_READ        = 1'b1;
    // APB register byte offsets.
    localparam logic [7:0] REG_STATUS      = 8'h00;
    localparam logic [7:0] REG_CTRL        = 8'h04;
    localparam logic [7:0] REG_MADDR       = 8'h08;
    localparam logic [7:0] REG_MDATA       = 8'h0c;
    localparam int         STAT_BUSY       = 0;
    localparam int         STAT_ACTIVE     = 1;
    localparam int         STAT_INHIBIT    = 2;
    localparam int         STAT_ADDR_LSB   = 16;
    localparam int         CTRL_ENABLE     = 0;
    localparam logic       CTRL_RESET      = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE, ST_DEVSEL, ST_ADDR_HI, ST_ADDR_LO, ST_WDATA, ST_RDATA
    } iee_state_t;
endpackage

/* rtl/iee_line_if.sv */
// Synchronised bus lines and line events passed from the monitor to the slave.
`timescale 1ns/100ps
interface iee_line_if;
    logic       scl_s;
    logic       sda_s;
    logic       scl_rise;
    logic       scl_fall;
    logic       start;
    logic       stop;
    logic       por_s;
    logic       inhibit_s;
    logic [2:0] strap_s;
    modport mon  (output scl_s, sda_s, scl_rise, scl_fall, start, stop, por_s, inhibit_s, strap_s);
    modport core (input  scl_s, sda_s, scl_rise, scl_fall, start, stop, por_s, inhibit_s, strap_s);
endinterface

/* rtl/iee_line_mon.sv */
// Pin synchronisers plus clock edge, Start and Stop detection.
`timescale 1ns/100ps
module iee_line_mon
    import iee_pkg::*;
(
    input  wire logic pclk,            // System clock.
    input  wire logic presetn,         // Asynchronous reset, active low.
    input  wire logic scl,             // Serial clock pin.
    input  wire logic sda_in,          // Serial data pin level.
    input  wire logic supply_reset,    // Supply-level reset indication.
    input  wire logic write_inhibit,   // Write inhibit pin.
    input  wire logic strap_sel_bit0,  // Select strap, bit one of the byte.
    input  wire logic strap_sel_bit1,  // Select strap, bit two of the byte.
    input  wire logic strap_sel_bit2,  // Select strap, bit three of the byte.
    iee_line_if.mon   line             // Synchronised lines and events.
);
    logic [LN_W-1:0] meta;
    logic [LN_W-1:0] sync;
    logic            scl_d;
    logic            sda_d;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta  <= LN_RESET;
            sync  <= LN_RESET;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            meta  <= {strap_sel_bit2, strap_sel_bit1, strap_sel_bit0, write_inhibit, supply_reset, sda_in, scl};
            sync  <= meta;
            scl_d <= sync[LN_SCL];
            sda_d <= sync[LN_SDA];
        end
    end

    assign line.scl_s     = sync[LN_SCL];
    assign line.sda_s     = sync[LN_SDA];
    assign line.por_s     = sync[LN_POR];
    assign line.inhibit_s = sync[LN_WI];
    assign line.strap_s   = sync[LN_STRAP +: 3];
    assign line.scl_rise  = sync[LN_SCL] & ~scl_d;
    assign line.scl_fall  = ~sync[LN_SCL] & scl_d;
    // Data edges while the clock stays high frame a transfer.
    assign line.start     = sync[LN_SCL] & scl_d & sda_d & ~sync[LN_SDA];   // see (R25)
    assign line.stop      = sync[LN_SCL] & scl_d & ~sda_d & sync[LN_SDA];   // see (R25)
endmodule // iee_line_mon

/* rtl/iee_slave.sv */
// Two-wire serial memory slave: byte protocol, page buffer, write cycle, APB access.
`timescale 1ns/100ps
module iee_slave
    import iee_pkg::*;
#(
    parameter logic [3:0] DEV_TYPE_ID     = 4'h6,            // Arbitrary value.
    parameter int         WRITE_CYCLE_LEN = WRITE_CYCLE_CYC  // Write cycle in clocks.
) (
    input  wire logic        pclk,            // System clock, 125 MHz.
    input  wire logic        presetn,         // Asynchronous reset, active low.
    input  wire logic        psel,            // APB select.
    input  wire logic        penable,         // APB enable.
    input  wire logic        pwrite,          // APB direction.
    input  wire logic [7:0]  paddr,           // APB byte address.
    input  wire logic [31:0] pwdata,          // APB write data.
    output logic      [31:0] prdata,          // APB read data.
    output logic             pready,          // APB ready.
    output logic             pslverr,         // APB error.
    input  wire logic        scl,             // Serial clock pin.
    input  wire logic        sda_in,          // Serial data pin level.
    output logic             sda_out,         // Serial data drive value, always low.
    output logic             sda_oe,          // Serial data pull-down enable.
    input  wire logic        write_inhibit,   // Write inhibit pin.
    input  wire logic        strap_sel_bit0,  // Select strap bit 0.
    input  wire logic        strap_sel_bit1,  // Select strap bit 1.
    input  wire logic        strap_sel_bit2,  // Select strap bit 2.
    input  wire logic        supply_reset     // Supply-level reset indication.
);
    iee_line_if line ();

    iee_line_mon u_mon (
        .pclk           (pclk),
        .presetn        (presetn),
        .scl            (scl),
        .sda_in         (sda_in),
        .supply_reset   (supply_reset),
        .write_inhibit  (write_inhibit),
        .strap_sel_bit0 (strap_sel_bit0),
        .strap_sel_bit1 (strap_sel_bit1),
        .strap_sel_bit2 (strap_sel_bit2),
        .line           (line)
    );

    function automatic logic [ADDR_W-1:0] page_inc(input logic [ADDR_W-1:0] a);
        page_inc = {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + 1'b1};
    endfunction

    logic [7:0]              mem [MEM_DEPTH];      // see (R18)
    logic [7:0]              pg_buf [PAGE_DEPTH];
    logic [PAGE_DEPTH-1:0]   pg_valid;
    iee_state_t              state;
    iee_state_t              nxt;

    logic [3:0]              bitcnt;
    logic                    in_ack;
    logic                    m_nack;
    logic                    wr_ack_end;
    logic [7:0]              shreg;
    logic [7:0]              tx;

    logic [7:0]              addr_hi;
    logic [ADDR_W-1:0]       addr;
    logic [ADDR_W-1:0]       maddr;
    logic                    busy;
    logic                    enable;
    logic [31:0]             cyc_cnt;
    logic [ADDR_W-PAGE_W-1:0] cmt_row;

    wire logic              live       = (state != ST_IDLE) & ~busy;
    wire logic              take_start = line.start & ~busy & enable & ~line.por_s;   // see (R04)
    wire logic              step       = live & ~line.por_s & ~take_start & ~line.stop;
    wire logic              rx_bit     = step & line.scl_rise & (bitcnt < LAST_BIT) & ~in_ack;  // see (R20)
    wire logic              byte_end   = step & line.scl_fall & (bitcnt == LAST_BIT) & ~in_ack;
    wire logic              ack_rise   = step & line.scl_rise & in_ack;
    wire logic              ack_end    = step & line.scl_fall & in_ack;
    wire logic              tx_bit     = step & line.scl_fall & (state == ST_RDATA) & ~in_ack
                                         & (bitcnt != 4'h0) & (bitcnt < LAST_BIT);

    wire logic [7:0]        rd_byte    = mem[addr];
    // Straps are expected to have external pull-downs, so open straps compare as zero.
    wire logic              dev_match  = (shreg[7:SEL_TYPE_LSB] == DEV_TYPE_ID)             // see (R06)
                                         & (shreg[SEL_STRAP_LSB +: 3] == line.strap_s);   // see (R07) (R08)

    wire logic              wr_take    = byte_end & (state == ST_WDATA) & ~line.inhibit_s; // see (R10) (R11)
    wire logic              addr_done  = byte_end & (state == ST_ADDR_LO);

    wire logic              commit_go  = line.stop & wr_ack_end & (|pg_valid) & ~busy & ~line.por_s; // see (R24)
    wire logic              cmt_on     = busy & (cyc_cnt < 32'(PAGE_DEPTH));
    wire logic [PAGE_W-1:0] cmt_idx    = cyc_cnt[PAGE_W-1:0];
    wire logic              cyc_last   = cyc_cnt == 32'(WRITE_CYCLE_LEN - 1);

    // Bit and byte sequencing of the serial protocol.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state      <= ST_IDLE;
            nxt        <= ST_IDLE;
            bitcnt     <= 4'h0;
            in_ack     <= 1'b0;
            m_nack     <= 1'b0;
            wr_ack_end <= 1'b0;
            shreg      <= 8'h00;
            tx         <= 8'h00;
            addr_hi    <= 8'h00;
            addr       <= '0;
            sda_oe     <= 1'b0;
            sda_out    <= 1'b0;
        end else if (line.por_s | take_start | line.stop | ~live) begin
            // Supply reset, new frame, Stop or write cycle all land in a known state.
            state      <= take_start ? ST_DEVSEL : ST_IDLE;                 // see (R13) (R14) (R15) (R16)
            bitcnt     <= 4'h0;
            in_ack     <= 1'b0;
            wr_ack_end <= 1'b0;
            sda_oe     <= 1'b0;
            sda_out    <= 1'b0;                                             // see (R17)
        end else begin
            sda_out <= 1'b0;
            if (rx_bit) begin
                shreg      <= {shreg[6:0], line.sda_s};                     // see (R09) (R22)
                bitcnt     <= bitcnt + 4'h1;
                // A Stop in the slot after a data ack still commits.
                wr_ack_end <= wr_ack_end & (bitcnt == 4'h0);                // see (R24)
            end
            if (ack_rise) begin
                m_nack     <= line.sda_s;                                   // see (R02)
                wr_ack_end <= 1'b0;
            end
            if (tx_bit) begin
                sda_oe <= ~tx[7];                                           // see (R17)
                tx     <= {tx[6:0], 1'b0};
            end
            if (byte_end) begin
                in_ack <= 1'b1;
                unique case (state)
                    ST_DEVSEL: begin
                        sda_oe <= dev_match;                                // see (R05)
                        nxt    <= (shreg[SEL_DIR] == DIR_READ) ? ST_RDATA : ST_ADDR_HI; // see (R21)
                        if (!dev_match) begin
                            state <= ST_IDLE;                               // see (R23)
                        end
                    end
                    ST_ADDR_HI: begin
                        addr_hi <= shreg;                                   // see (R19)
                        sda_oe  <= 1'b1;                                    // see (R12)
                        nxt     <= ST_ADDR_LO;
                    end
                    ST_ADDR_LO: begin
                        addr   <= ADDR_W'({addr_hi, shreg});                // see (R19)
                        sda_oe <= 1'b1;
                        nxt    <= ST_WDATA;
                    end
                    ST_WDATA: begin
                        sda_oe <= ~line.inhibit_s;                          // see (R01) (R12)
                        nxt    <= ST_WDATA;
                        if (!line.inhibit_s) begin
                            addr <= page_inc(addr);
                        end
                    end
                    ST_RDATA: begin
                        sda_oe <= 1'b0;
                        nxt    <= ST_RDATA;
                        addr   <= addr + 1'b1;
                    end
                    ST_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
            if (ack_end) begin
                in_ack     <= 1'b0;
                bitcnt     <= 4'h0;
                wr_ack_end <= (state == ST_WDATA) & sda_oe;
                if ((state == ST_RDATA) & m_nack) begin
                    state  <= ST_IDLE;                                      // see (R03)
                    sda_oe <= 1'b0;
                end else begin
                    state  <= nxt;
                    sda_oe <= (nxt == ST_RDATA) & ~rd_byte[7];
                    tx     <= {rd_byte[6:0], 1'b0};
                end
            end
        end
    end

    // Page buffer bookkeeping and the self-timed write cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pg_valid <= '0;
            busy     <= 1'b0;
            cyc_cnt  <= 32'h0;
            cmt_row  <= '0;
        end else if (line.por_s) begin
            pg_valid <= '0;
            busy     <= 1'b0;
            cyc_cnt  <= 32'h0;
        end else if (busy) begin
            cyc_cnt <= cyc_cnt + 32'h1;                                     // see (R26)
            if (cyc_last) begin
                busy     <= 1'b0;
                pg_valid <= '0;
            end
        end else if (commit_go) begin
            busy    <= 1'b1;                                                // see (R24)
            cyc_cnt <= 32'h0;
            cmt_row <= addr[ADDR_W-1:PAGE_W];
        end else if (addr_done) begin
            pg_valid <= '0;
        end else if (wr_take) begin
            pg_valid[addr[PAGE_W-1:0]] <= 1'b1;
        end
    end

    // APB slave: one wait state, writes land on the edge that sees pready.
    wire logic sel_status = paddr == REG_STATUS;
    wire logic sel_ctrl   = paddr == REG_CTRL;
    wire logic sel_maddr  = paddr == REG_MADDR;
    wire logic sel_mdata  = paddr == REG_MDATA;
    wire logic mapped     = sel_status | sel_ctrl | sel_maddr | sel_mdata;
    wire logic acc        = psel & penable & ~pready;
    wire logic fire       = psel & penable & pready & pwrite & ~pslverr;
    wire logic apb_mwr    = fire & sel_mdata & ~busy;
    wire logic [31:0] status_word = (32'(addr) << STAT_ADDR_LSB)
                                    | (32'(line.inhibit_s) << STAT_INHIBIT)
                                    | (32'(state != ST_IDLE) << STAT_ACTIVE)
                                    | (32'(busy) << STAT_BUSY);
    wire logic [31:0] rd_mux = sel_status ? status_word
                             : sel_ctrl   ? (32'(enable) << CTRL_ENABLE)
                             : sel_maddr  ? 32'(maddr)
                             : sel_mdata  ? 32'(mem[maddr])
                             : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
            enable  <= CTRL_RESET;
            maddr   <= '0;
        end else begin
            pready  <= acc;
            pslverr <= acc & (~mapped | (sel_mdata & pwrite & busy));
            prdata  <= (acc & ~pwrite) ? rd_mux : 32'h0;
            if (fire & sel_ctrl) begin
                enable <= pwdata[CTRL_ENABLE];
            end
            if (fire & sel_maddr) begin
                maddr <= pwdata[ADDR_W-1:0];
            end
        end
    end

    // Array and page buffer storage; the write cycle has priority on the array port.
    always_ff @(posedge pclk) begin
        if (cmt_on & pg_valid[cmt_idx]) begin
            mem[{cmt_row, cmt_idx}] <= pg_buf[cmt_idx];                    // see (R24)
        end else if (apb_mwr) begin
            mem[maddr] <= pwdata[7:0];
        end
        if (wr_take) begin
            pg_buf[addr[PAGE_W-1:0]] <= shreg;
        end
    end

    // Checks of the serial byte protocol.
    drive_low_a: assert property (@(posedge pclk) disable iff (!presetn) sda_oe |-> !sda_out) // see (R17)
        else $error("data line driven high");

    oe_change_a: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(sda_oe) |-> !line.scl_s) // see (R22)
        else $error("data drive changed with clock high");

    sel_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
        byte_end && state == ST_DEVSEL && dev_match |=> sda_oe && in_ack) // see (R05)
        else $error("matching select byte not acked");

    sel_miss_a: assert property (@(posedge pclk) disable iff (!presetn)
        byte_end && state == ST_DEVSEL && !dev_match |=> !sda_oe ##1 state == ST_IDLE) // see (R23)
        else $error("mismatched select byte not dropped");

    dir_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        ack_end && state == ST_DEVSEL && shreg[SEL_DIR] == DIR_READ
        |=> state == ST_RDATA) // see (R21)
        else $error("read select not served");

    addr_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
        byte_end && (state == ST_ADDR_HI || state == ST_ADDR_LO)
        |=> sda_oe) // see (R12) (R19)
        else $error("address byte not acked");

    inhibit_nack_a: assert property (@(posedge pclk) disable iff (!presetn)
        byte_end && state == ST_WDATA && line.inhibit_s |=> !sda_oe && $stable(pg_valid)) // see (R10) (R12)
        else $error("inhibited data byte acked or stored");

    data_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
        byte_end && state == ST_WDATA && !line.inhibit_s |=> sda_oe) // see (R01)
        else $error("data byte not acked");

    rd_release_a: assert property (@(posedge pclk) disable iff (!presetn)
        byte_end && state == ST_RDATA
        |=> in_ack && !sda_oe) // see (R02)
        else $error("read ack slot not released");

    rd_nack_a: assert property (@(posedge pclk) disable iff (!presetn)
        ack_end && state == ST_RDATA && m_nack
        |=> state == ST_IDLE && !sda_oe) // see (R03)
        else $error("read not ended on nack");

    supply_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        line.por_s |=> state == ST_IDLE && !sda_oe && !busy) // see (R13) (R14) (R15)
        else $error("activity under supply reset");

    stop_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        line.stop |=> state == ST_IDLE && !sda_oe) // see (R16)
        else $error("stop did not reach standby");

    // Checks of the write cycle and the register port.
    cycle_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        commit_go |=> busy[*8]) // see (R24) (R26)
        else $error("write cycle not started");

    stray_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        line.stop && !busy && !wr_ack_end
        |=> !busy) // see (R24)
        else $error("write cycle without data ack");

    cycle_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        busy && cyc_last && !line.por_s
        |=> !busy) // see (R26)
        else $error("write cycle overran");

    busy_deaf_a: assert property (@(posedge pclk) disable iff (!presetn)
        busy && line.start |=> state == ST_IDLE && !sda_oe) // see (R26)
        else $error("bus answered during write cycle");

    apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer not one wait state");

    apb_error_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready && !mapped
        |=> pready && pslverr)
        else $error("unmapped access not refused");
endmodule // iee_slave

/* testbench/iee_bus_master.sv */
// Behavioural two-wire bus master that clocks the link and pulls the data line low.
`timescale 1ns/100ps
module iee_bus_master (
    output logic      scl,      // Serial clock, high between frames.
    output logic      sda_low,  // High while the master pulls data low.
    input  wire logic sda       // Resolved data line level.
);
    logic r;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic bit_x(input logic b, output logic s);
        #8 sda_low = !b;
        #24 scl = 1'b1;
        #31 s = sda;
        #1 scl = 1'b0;
    endtask
    // The first wait keeps the link out of phase with the system clock.
    task automatic start_c();
        #3;
        if (!scl) begin
            sda_low = 1'b0;
            #40 scl = 1'b1;
        end
        #32 sda_low = 1'b1;
        #32 scl = 1'b0;
    endtask
    task automatic stop_c();
        #8 sda_low = 1'b1;
        #24 scl = 1'b1;
        #32 sda_low = 1'b0;
        #32;
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask
    task automatic recv_byte(input logic ack, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(!ack, r);
    endtask
endmodule // iee_bus_master

/* testbench/test_iee_slave.sv */
// Self-checking bench of the serial memory slave driven by a behavioural bus master.
`timescale 1ns/100ps
module test_iee_slave;
    import iee_pkg::*;
    localparam logic [3:0] TYPE_ID = 4'h6;  // Arbitrary value.
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        scl;
    logic        m_low;
    logic        sda_out;
    logic        sda_oe;
    logic        write_inhibit = 1'b0;
    logic [2:0]  strap = 3'h0;
    logic        supply_reset = 1'b1;
    logic [31:0] seed = 32'hd770;
    logic [31:0] rd;
    logic        er;
    logic        ak;
    logic [7:0]  rb;
    logic [13:0] a;
    logic [7:0]  d;
    int          err_count = 0;
    int          check_count = 0;
    wire         sda = !(m_low || (sda_oe && !sda_out));
    always #4 pclk = !pclk;
    iee_bus_master u_iee_bus_master (.scl(scl), .sda_low(m_low), .sda(sda));
    iee_slave #(.DEV_TYPE_ID(TYPE_ID), .WRITE_CYCLE_LEN(200)) u_iee_slave (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .write_inhibit(write_inhibit), .strap_sel_bit0(strap[0]), .strap_sel_bit1(strap[1]),
        .strap_sel_bit2(strap[2]), .supply_reset(supply_reset));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] time %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_count++;
            end_of_test();
        end
    endtask
    task automatic sb(input logic [7:0] b, input logic e);
        u_iee_bus_master.send_byte(b, ak);
        chk(32'(ak), 32'(e));
    endtask
    task automatic hdr(input logic [13:0] ad);
        u_iee_bus_master.start_c();
        sb({TYPE_ID, strap, 1'b0}, 1'b1);
        sb({2'h0, ad[13:8]}, 1'b1);
        sb(ad[7:0], 1'b1);
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        supply_reset <= 1'b0;
        repeat (6) @(posedge pclk);
        apb(1'b0, REG_CTRL, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, REG_STATUS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, er}, 32'h1);
        for (int k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            a = seed[29:16];
            d = seed[7:0];
            hdr(a);
            sb(d, 1'b1);
            u_iee_bus_master.stop_c();
            apb(1'b0, REG_STATUS, 32'h0);
            chk(32'(rd[STAT_BUSY]), 32'h1);
            u_iee_bus_master.start_c();
            sb({TYPE_ID, strap, 1'b0}, 1'b0);
            u_iee_bus_master.stop_c();
            for (int n = 0; n < 100 && rd[STAT_BUSY] !== 1'b0; n++) apb(1'b0, REG_STATUS, 32'h0);
            chk(rd, {2'h0, a[13:6], 6'(a[5:0] + 6'h1), 16'h0});
            apb(1'b1, REG_MADDR, 32'(a));
            apb(1'b0, REG_MDATA, 32'h0);
            chk(rd, 32'(d));
            strap <= seed[10:8];
            hdr(a);
            u_iee_bus_master.start_c();
            sb({TYPE_ID, seed[10:8], 1'b1}, 1'b1);
            u_iee_bus_master.recv_byte(1'b0, rb);
            chk(32'(rb), 32'(d));
            u_iee_bus_master.stop_c();
        end
        for (int k = 0; k < 4; k++) begin
            u_iee_bus_master.start_c();
            sb(k == 3 ? {~TYPE_ID, strap, 1'b0} : {TYPE_ID, strap ^ (3'h1 << k), 1'b0}, 1'b0);
            u_iee_bus_master.stop_c();
        end
        @(posedge pclk);
        write_inhibit <= 1'b1;
        hdr(a);
        sb(~d, 1'b0);
        u_iee_bus_master.stop_c();
        apb(1'b0, REG_STATUS, 32'h0);
        chk(rd, {2'h0, a, 16'h4});
        apb(1'b0, REG_MDATA, 32'h0);
        chk(rd, 32'(d));
        write_inhibit <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            @(posedge pclk);
            supply_reset <= k[0];
            apb(1'b1, REG_CTRL, 32'(k[0]));
            repeat (4) @(posedge pclk);
            u_iee_bus_master.start_c();
            sb({TYPE_ID, strap, 1'b0}, 1'b0);
            u_iee_bus_master.stop_c();
        end
        @(posedge pclk);
        supply_reset <= 1'b0;
        apb(1'b0, REG_CTRL, 32'h0);
        chk(rd, 32'h1);
        repeat (4) @(posedge pclk);
        u_iee_bus_master.start_c();
        sb({TYPE_ID, strap, 1'b0}, 1'b1);
        u_iee_bus_master.stop_c();
        end_of_test();
    end
endmodule // test_iee_slave
